// ### design/atsm_alert_mask.sv
// Purpose: Second alert pin mask register and pin function logic
// Assumes: Status inputs are the latched and live flags, synchronous to clk_sys
// Notes: Pin is open drain style, oe_n low pulls the line low

`timescale 1ns/1ns
`default_nettype none

module atsm_alert_mask
  import atsm_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire atsm_cmd_t cmd,
  output var atsm_rsp_t rsp,
  input wire atsm_src_t latched_status,
  input wire atsm_src_t live_status,
  input wire logic retry_fail,
  output logic second_alert_pin_out,
  output logic second_alert_pin_oe_n,
  output logic alert_active,
  output logic [15:0] mask_value
);

  // Register group
  logic [15:0] cfg_q;
  logic [15:0] cfg_d;
  logic health_arm_q;
  logic health_arm_d;
  atsm_rsp_t rsp_q;
  atsm_rsp_t rsp_d;
  logic cmd_hit;
  logic wr_hit;

  // Pin group
  logic pin_oe_n_q;
  logic pin_oe_n_d;
  logic pin_out_q;
  logic active_q;
  logic active_d;
  logic [ATSM_NUM_SRC-1:0] eff_en;
  logic latched_hit;
  logic live_hit;
  logic [1:0] pin_mode;
  logic pin_pol;

  assign cmd_hit = cmd.valid && (cmd.code == ATSM_CMD_CODE);
  assign wr_hit = cmd_hit && cmd.write;

  always_comb begin
    cfg_d = cfg_q;
    health_arm_d = health_arm_q;
    if (wr_hit) begin
      cfg_d = cmd.wdata;
      // Arm holds until the host sets bit 15 itself, so picking alert mode
      // with an empty mask cannot silence a bad transistor
      if (cmd.wdata[ATSM_HEALTH_BIT]) begin
        health_arm_d = 1'b0;
      end
    end
    rsp_d.valid = cmd.valid;
    rsp_d.hit = cmd_hit;
    rsp_d.rdata = ATSM_ZERO_WORD;
    if (cmd_hit && !cmd.write) begin
      rsp_d.rdata = cfg_q;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cfg_q <= ATSM_RESET_VALUE;
      health_arm_q <= 1'b1;
      rsp_q <= '0;
    end else begin
      cfg_q <= cfg_d;
      health_arm_q <= health_arm_d;
      rsp_q <= rsp_d;
    end
  end

  // Stored bit 15 reads as zero after reset, yet the source is live until software
  // sets that bit itself, so alert and comparator modes never miss a bad transistor at start-up. To mute
  // it the host must set bit 15 once and then clear it.
  always_comb begin
    eff_en = cfg_q[ATSM_SRC_MSB:ATSM_SRC_LSB];
    eff_en[ATSM_NUM_SRC-1] = cfg_q[ATSM_HEALTH_BIT] | health_arm_q;
  end

  assign latched_hit = |(latched_status & eff_en);
  assign live_hit = |(live_status & eff_en);
  assign pin_mode = cfg_q[ATSM_MODE_MSB:ATSM_MODE_LSB];
  assign pin_pol = cfg_q[ATSM_POL_BIT];

  always_comb begin
    active_d = 1'b0;
    case (pin_mode)
      ATSM_MODE_ALERT: begin
        // Holds as long as the latched flag does; the host clears it elsewhere
        active_d = latched_hit;
      end
      ATSM_MODE_GPO: begin
        active_d = !pin_pol;
      end
      ATSM_MODE_RETRY: begin
        active_d = retry_fail;
      end
      ATSM_MODE_COMP: begin
        // Unlatched view, so a short glitch is seen only while it lasts
        active_d = live_hit;
      end
      default: begin
        active_d = 1'b0;
      end
    endcase
    pin_oe_n_d = !active_d;
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pin_oe_n_q <= 1'b1;
      pin_out_q <= 1'b0;
      active_q <= 1'b0;
    end else begin
      pin_oe_n_q <= pin_oe_n_d;
      pin_out_q <= 1'b0;
      active_q <= active_d;
    end
  end

  assign rsp = rsp_q;
  assign second_alert_pin_out = pin_out_q;
  assign second_alert_pin_oe_n = pin_oe_n_q;
  assign alert_active = active_q;
  assign mask_value = cfg_q;

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  logic alert_mode;
  assign alert_mode = (pin_mode == ATSM_MODE_ALERT);

  reset_value_a: assert property (@(posedge clk_sys) disable iff (1'b0)
      rst |=> cfg_q == ATSM_RESET_VALUE)
    else $error("mask register not at reset value");

  write_update_a: assert property (wr_hit |=> cfg_q == $past(cmd.wdata))
    else $error("mask write not stored");

  read_answer_a: assert property (cmd_hit && !cmd.write |=> rsp.valid && rsp.hit
      && rsp.rdata == $past(cfg_q))
    else $error("mask read answer wrong");

  unmapped_answer_a: assert property (cmd.valid && !cmd_hit
      |=> rsp.valid && !rsp.hit && rsp.rdata == ATSM_ZERO_WORD)
    else $error("unmapped command answer wrong");

  unmapped_keep_a: assert property (cmd.valid && !cmd_hit |=> cfg_q == $past(cfg_q))
    else $error("unmapped command changed mask");

  idle_answer_a: assert property (!cmd.valid |=> !rsp.valid)
    else $error("answer without command");

  health_alert_a: assert property (alert_mode && cfg_q[ATSM_HEALTH_BIT]
      && latched_status.transistor_health_failure_flag |=> !second_alert_pin_oe_n)
    else $error("health alert not raised");

  health_masked_a: assert property (alert_mode && !health_arm_q
      && !cfg_q[ATSM_HEALTH_BIT] && latched_status == 13'h1000 |=> second_alert_pin_oe_n)
    else $error("disabled health source raised alert");

  health_boot_a: assert property (alert_mode && health_arm_q
      && latched_status.transistor_health_failure_flag |=> !second_alert_pin_oe_n)
    else $error("health alert not live before handover");

  health_arm_reset_a: assert property (@(posedge clk_sys) disable iff (1'b0)
      rst |=> health_arm_q)
    else $error("health arm not set by reset");

  health_hand_a: assert property (wr_hit && cmd.wdata[ATSM_HEALTH_BIT]
      |=> !health_arm_q)
    else $error("health arm not handed over");

  oc_fault_a: assert property (alert_mode && cfg_q[ATSM_OC_FAULT_BIT]
      && latched_status.overcurrent_fault_flag |=> !second_alert_pin_oe_n)
    else $error("overcurrent fault alert missing");

  oc_fault_off_a: assert property (alert_mode && !cfg_q[ATSM_OC_FAULT_BIT]
      && latched_status == 13'h0800 |=> second_alert_pin_oe_n)
    else $error("disabled overcurrent fault raised alert");

  input_overvoltage_fault_flag_a: assert property (alert_mode && cfg_q[ATSM_INPUT_OVERVOLTAGE_FAULT_FLAG_BIT]
      && latched_status.input_overvoltage_fault_flag |=> !second_alert_pin_oe_n)
    else $error("input overvoltage fault alert missing");

  input_overvoltage_fault_flag_off_a: assert property (alert_mode && !cfg_q[ATSM_INPUT_OVERVOLTAGE_FAULT_FLAG_BIT]
      && latched_status == 13'h0400 |=> second_alert_pin_oe_n)
    else $error("disabled input overvoltage fault raised alert");

  input_undervoltage_fault_flag_a: assert property (alert_mode && cfg_q[ATSM_INPUT_UNDERVOLTAGE_FAULT_FLAG_BIT]
      && latched_status.input_undervoltage_fault_flag |=> !second_alert_pin_oe_n)
    else $error("input undervoltage fault alert missing");

  input_undervoltage_fault_flag_off_a: assert property (alert_mode && !cfg_q[ATSM_INPUT_UNDERVOLTAGE_FAULT_FLAG_BIT]
      && latched_status == 13'h0200 |=> second_alert_pin_oe_n)
    else $error("disabled input undervoltage fault raised alert");

  comm_error_a: assert property (alert_mode && cfg_q[ATSM_CML_BIT]
      && latched_status.comm_logic_error_flag |=> !second_alert_pin_oe_n)
    else $error("communication error alert missing");

  comm_error_off_a: assert property (alert_mode && !cfg_q[ATSM_CML_BIT]
      && latched_status == 13'h0100 |=> second_alert_pin_oe_n)
    else $error("disabled communication error raised alert");

  oc_warn_a: assert property (alert_mode && cfg_q[ATSM_OC_WARN_BIT]
      && latched_status.overcurrent_warning_flag |=> !second_alert_pin_oe_n)
    else $error("overcurrent warning alert missing");

  oc_warn_off_a: assert property (alert_mode && !cfg_q[ATSM_OC_WARN_BIT]
      && latched_status == 13'h0080 |=> second_alert_pin_oe_n)
    else $error("disabled overcurrent warning raised alert");

  warn_two_a: assert property (alert_mode && cfg_q[ATSM_WARN2_BIT]
      && latched_status.secondary_current_warning_flag |=> !second_alert_pin_oe_n)
    else $error("secondary current warning alert missing");

  warn_two_off_a: assert property (alert_mode && !cfg_q[ATSM_WARN2_BIT]
      && latched_status == 13'h0040 |=> second_alert_pin_oe_n)
    else $error("disabled secondary current warning raised alert");

  input_overvoltage_warning_flag_a: assert property (alert_mode && cfg_q[ATSM_INPUT_OVERVOLTAGE_WARNING_FLAG_BIT]
      && latched_status.input_overvoltage_warning_flag |=> !second_alert_pin_oe_n)
    else $error("input overvoltage warning alert missing");

  input_overvoltage_warning_flag_off_a: assert property (alert_mode && !cfg_q[ATSM_INPUT_OVERVOLTAGE_WARNING_FLAG_BIT]
      && latched_status == 13'h0020 |=> second_alert_pin_oe_n)
    else $error("disabled input overvoltage warning raised alert");

  reset_disable_a: assert property (@(posedge clk_sys) disable iff (1'b0)
      rst |=> cfg_q[ATSM_SRC_MSB:ATSM_SRC_LSB] == '0)
    else $error("enable bits not cleared by reset");

  uv_warn_a: assert property (alert_mode && cfg_q[ATSM_VIN_UV_WARN_BIT]
      && latched_status.input_undervoltage_warning_flag |=> !second_alert_pin_oe_n)
    else $error("input undervoltage warning alert missing");

  aux_ov_warn_a: assert property (alert_mode && cfg_q[ATSM_AUX_OV_WARN_BIT]
      && latched_status.aux_overvoltage_warning_flag |=> !second_alert_pin_oe_n)
    else $error("auxiliary overvoltage warning alert missing");

  aux_uv_warn_a: assert property (alert_mode && cfg_q[ATSM_AUX_UV_WARN_BIT]
      && latched_status.aux_undervoltage_warning_flag |=> !second_alert_pin_oe_n)
    else $error("auxiliary undervoltage warning alert missing");

  limit_fault_a: assert property (alert_mode && cfg_q[ATSM_LIMIT_FAULT_BIT]
      && latched_status.current_limit_fault_flag |=> !second_alert_pin_oe_n)
    else $error("current limit fault alert missing");

  power_warn_a: assert property (alert_mode && cfg_q[ATSM_POWER_WARN_BIT]
      && latched_status.input_power_warning_flag |=> !second_alert_pin_oe_n)
    else $error("input power warning alert missing");

  retry_mode_a: assert property (pin_mode == ATSM_MODE_RETRY
      |=> second_alert_pin_oe_n == !$past(retry_fail))
    else $error("retry fail output wrong");

  comp_mode_a: assert property (pin_mode == ATSM_MODE_COMP && !live_hit
      |=> second_alert_pin_oe_n)
    else $error("comparator mode drives without live status");

  comp_assert_a: assert property (pin_mode == ATSM_MODE_COMP && cfg_q[ATSM_HEALTH_BIT]
      && live_status.transistor_health_failure_flag |=> !second_alert_pin_oe_n)
    else $error("comparator mode misses live status");

  pin_reset_a: assert property (@(posedge clk_sys) disable iff (1'b0)
      rst |=> second_alert_pin_oe_n && !alert_active && !second_alert_pin_out)
    else $error("pin not released by reset");

  gpo_level_a: assert property (pin_mode == ATSM_MODE_GPO
      |=> second_alert_pin_oe_n == $past(pin_pol))
    else $error("output mode polarity wrong");

  masked_quiet_a: assert property (alert_mode && !latched_hit
      |=> second_alert_pin_oe_n && !alert_active)
    else $error("alert raised by masked source");

  alert_hold_a: assert property (alert_mode && latched_hit ##1 alert_mode && latched_hit
      |=> !second_alert_pin_oe_n [*1] ##0 alert_active)
    else $error("alert dropped while status held");

  pin_low_a: assert property (second_alert_pin_out == 1'b0)
    else $error("pin data must stay low");

  write_alert_c: cover property (wr_hit ##1 alert_mode ##1 !second_alert_pin_oe_n);
  health_boot_c: cover property (health_arm_q && latched_status.transistor_health_failure_flag
      ##1 !second_alert_pin_oe_n);
  comp_live_c: cover property (pin_mode == ATSM_MODE_COMP && live_hit ##1 !second_alert_pin_oe_n);
  retry_c: cover property (pin_mode == ATSM_MODE_RETRY && retry_fail ##1 alert_active);
  mask_off_c: cover property (alert_mode && !health_arm_q && latched_status != '0
      ##1 second_alert_pin_oe_n);

endmodule

`default_nettype wire

// ### design/atsm_pkg.sv
// Purpose: Shared constants and carriers for the second alert source mask
// Assumes: Decoded word commands arrive from the management bus front end
// Notes: Source order in atsm_src_t matches mask bits 15 down to 3

package atsm_pkg;

  // Command code and value after reset of the mask register
  localparam logic [7:0] ATSM_CMD_CODE = 8'hd6;
  localparam logic [15:0] ATSM_RESET_VALUE = 16'h0004;
  localparam logic [15:0] ATSM_ZERO_WORD = 16'h0000;

  // Field positions
  localparam int ATSM_HEALTH_BIT = 15;
  localparam int ATSM_OC_FAULT_BIT = 14;
  localparam int ATSM_INPUT_OVERVOLTAGE_FAULT_FLAG_BIT = 13;
  localparam int ATSM_INPUT_UNDERVOLTAGE_FAULT_FLAG_BIT = 12;
  localparam int ATSM_CML_BIT = 11;
  localparam int ATSM_OC_WARN_BIT = 10;
  localparam int ATSM_WARN2_BIT = 9;
  localparam int ATSM_INPUT_OVERVOLTAGE_WARNING_FLAG_BIT = 8;
  localparam int ATSM_VIN_UV_WARN_BIT = 7;
  localparam int ATSM_AUX_OV_WARN_BIT = 6;
  localparam int ATSM_AUX_UV_WARN_BIT = 5;
  localparam int ATSM_LIMIT_FAULT_BIT = 4;
  localparam int ATSM_POWER_WARN_BIT = 3;
  localparam int ATSM_SRC_MSB = 15;
  localparam int ATSM_SRC_LSB = 3;
  localparam int ATSM_NUM_SRC = 13;
  localparam int ATSM_MODE_MSB = 2;
  localparam int ATSM_MODE_LSB = 1;
  localparam int ATSM_POL_BIT = 0;

  // Pin function select codes
  localparam logic [1:0] ATSM_MODE_ALERT = 2'h0;
  localparam logic [1:0] ATSM_MODE_GPO = 2'h1;
  localparam logic [1:0] ATSM_MODE_RETRY = 2'h2;
  localparam logic [1:0] ATSM_MODE_COMP = 2'h3;

  // Status sources, most significant first, aligned with mask bits 15..3
  typedef struct packed {
    logic transistor_health_failure_flag;
    logic overcurrent_fault_flag;
    logic input_overvoltage_fault_flag;
    logic input_undervoltage_fault_flag;
    logic comm_logic_error_flag;
    logic overcurrent_warning_flag;
    logic secondary_current_warning_flag;
    logic input_overvoltage_warning_flag;
    logic input_undervoltage_warning_flag;
    logic aux_overvoltage_warning_flag;
    logic aux_undervoltage_warning_flag;
    logic current_limit_fault_flag;
    logic input_power_warning_flag;
  } atsm_src_t;

  // Decoded word command from the management bus
  typedef struct packed {
    logic valid;
    logic write;
    logic [7:0] code;
    logic [15:0] wdata;
  } atsm_cmd_t;

  // Answer to a command, one cycle after it is taken
  typedef struct packed {
    logic valid;
    logic hit;
    logic [15:0] rdata;
  } atsm_rsp_t;

endpackage

// ### tb/atsm_host_model.sv
// Purpose: Host side of the second alert line, with the board pull-up
// Assumes: The pin is open drain, oe_n low pulls the line low
// Notes: Released line reads high, never the last driven value
`timescale 1ns/1ns
`default_nettype none
module atsm_host_model (
  input wire logic pin_out,
  input wire logic pin_oe_n,
  output logic alert_line
);
  // Pull-up wins whenever the device lets go of the line
  assign alert_line = pin_oe_n ? 1'b1 : pin_out;
endmodule
`default_nettype wire

// ### tb/alert_two_source_mask_tb.sv
// Purpose: Self-checking bench for the second alert source mask
// Assumes: Commands are one-cycle pulses, answers come one cycle later
// Notes: Health arm shows once alert mode is written with bit 15 still clear
`timescale 1ns/1ns
`default_nettype none
module alert_two_source_mask_tb;
  import atsm_pkg::*;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  atsm_cmd_t cmd = '0;
  atsm_rsp_t rsp;
  logic [12:0] lat = 13'h0000;
  logic [12:0] live = 13'h0000;
  logic retry_fail = 1'b0;
  logic pin_out, oe_n, act, line;
  logic [15:0] mask_value;
  int n_errors = 0;
  int n_compared = 0;
  atsm_rsp_t r;
  always #5 clk_sys = ~clk_sys;
  atsm_alert_mask dut_u (.clk_sys(clk_sys), .rst(rst), .cmd(cmd), .rsp(rsp),
    .latched_status(atsm_src_t'(lat)), .live_status(atsm_src_t'(live)),
    .retry_fail(retry_fail), .second_alert_pin_out(pin_out),
    .second_alert_pin_oe_n(oe_n), .alert_active(act), .mask_value(mask_value));
  atsm_host_model host_u (.pin_out(pin_out), .pin_oe_n(oe_n), .alert_line(line));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic op(input logic w, input logic [7:0] c, input logic [15:0] d);
    @(posedge clk_sys);
    cmd <= '{1'b1, w, c, d};
    @(posedge clk_sys);
    cmd <= '0;
    #1 r = rsp;
  endtask
  // Line level as the host sees it; low means the alert is asserted
  task automatic pin(input logic exp, input string m);
    repeat (3) @(posedge clk_sys);
    #1 chk({15'h0000, line}, {15'h0000, exp}, m);
    chk({15'h0000, act}, {15'h0000, ~exp}, "active flag");
  endtask
  task automatic t_reset();
    chk(mask_value, 16'h0004, "reset value");
    op(1'b0, 8'hd6, 16'h0000);
    chk({14'h0000, r.valid, r.hit}, 16'h0003, "read flags");
    chk(r.rdata, 16'h0004, "reset read");
    @(posedge clk_sys) retry_fail <= 1'b1;
    pin(1'b0, "retry asserted");
    @(posedge clk_sys) retry_fail <= 1'b0;
    pin(1'b1, "retry released");
    $display("test reset done");
  endtask
  task automatic t_sources();
    for (int b = 15; b >= 3; b--) begin
      op(1'b1, 8'hd6, 16'h0001 << b);
      op(1'b0, 8'hd6, 16'h0000);
      chk(r.rdata, 16'h0001 << b, "read back");
      @(posedge clk_sys) lat <= ~(13'h0001 << (b - 3));
      pin(1'b1, "others masked");
      @(posedge clk_sys) lat <= 13'h0001 << (b - 3);
      pin(1'b0, "enabled source");
      @(posedge clk_sys) lat <= 13'h0000;
      pin(1'b1, "status cleared");
    end
    $display("test sources done");
  endtask
  task automatic t_modes();
    op(1'b1, 8'hd6, 16'h0002);
    pin(1'b0, "output active low");
    op(1'b1, 8'hd6, 16'h0003);
    pin(1'b1, "output inverted");
    op(1'b1, 8'hd6, 16'h8006);
    @(posedge clk_sys) lat <= 13'h1000;
    pin(1'b1, "comparator ignores latch");
    @(posedge clk_sys) live <= 13'h1000;
    pin(1'b0, "comparator live");
    @(posedge clk_sys) begin
      live <= 13'h0000;
      lat <= 13'h0000;
    end
    pin(1'b1, "comparator clear");
    $display("test modes done");
  endtask
  task automatic t_unmapped();
    op(1'b1, 8'hd7, 16'hffff);
    chk({14'h0000, r.valid, r.hit}, 16'h0002, "unmapped flags");
    chk(r.rdata, 16'h0000, "unmapped write");
    chk(mask_value, 16'h8006, "mask kept");
    $display("test unmapped done");
  endtask
  // Mid-run reset re-arms the health source; an empty alert mask must not mute it
  task automatic t_health();
    @(posedge clk_sys) rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    #1 chk(mask_value, 16'h0004, "reset again");
    op(1'b1, 8'hd6, 16'h0000);
    @(posedge clk_sys) lat <= 13'h1000;
    pin(1'b0, "health armed");
    op(1'b1, 8'hd6, 16'h8000);
    pin(1'b0, "health by bit");
    op(1'b1, 8'hd6, 16'h0000);
    pin(1'b1, "health masked");
    for (int k = 0; k < 13; k++) begin
      @(posedge clk_sys) lat <= 13'h0001 << k;
      pin(1'b1, "disabled source");
    end
    @(posedge clk_sys) lat <= 13'h0000;
    $display("test health done");
  endtask
  task automatic results();
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge clk_sys);
    rst <= 1'b0;
    #1;
    t_reset();
    t_sources();
    t_modes();
    t_unmapped();
    t_health();
    results();
  end
  // Cuts a hang short
  initial begin
    repeat (20000) @(posedge clk_sys);
    n_errors++;
    results();
  end
endmodule
`default_nettype wire
